// File: rtl/dtc_device.sv
// datapath end of the sample link
// Behaviour
// [RL1] input bus never above 250 MHz
// [RL2] update rate never above 1000 MHz
// [RL3] beats per sample by width; dual-full halves bus
// [RL4] each half-band stage doubles output rate
// [RL5] prefer first stages; later ones save power
// [RL6] coarse modulation shifts spectrum by rate fraction
// [RL7] half, quarter, three-quarter mixing sequences
// [RL8] eighth-rate eight-step sequence with r scaling
// [RL9] only half-rate keeps channels independent
// [RL10] I code 1000000000 skews away 1.75 degrees
// [RL11] I max code skews toward 1.75 degrees
// [RL12] Q phase control behaves symmetrically
// [RL13] phase skew linear over 1024 codes
// [RL14] 16-bit offsets added per path
// [RL15] software keeps offset sums in range
// [RL16] samples twos complement, zero is midscale
// [RL17] inverse sinc is nine-tap FIR, 3.2 dB loss
// [RL18] composite ripple small up to 0.4 rate
// [RL19] bypass bit 6 of 0x1B removes sinc
// [RL20] inverse sinc enabled after reset
// [RL21] mixer steps per sample, restarts on change
// [RL22] premodulation shifts input by half rate
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dtc_device (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link to host
  dtc_if.dev lnk,
  // converter side
  output logic signed [15:0] dac_i,
  output logic signed [15:0] dac_q,
  output logic dac_stb
);
  // configuration state
  logic sinc_bypass;
  dtc_pkg::dtc_bus_t bus_mode;
  logic [2:0] hb_en;
  logic premod;
  dtc_pkg::dtc_mod_t mod_sel;
  logic [9:0] ph_i;
  logic [9:0] ph_q;
  logic [15:0] off_i;
  logic [15:0] off_q;

  // config writes; unknown addresses are ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sinc_bypass <= dtc_pkg::SINC_BYP_RST; // RL20
      bus_mode <= dtc_pkg::DTC_BUS_BYTE;
      hb_en <= 3'b000;
      premod <= 1'b0;
      mod_sel <= dtc_pkg::DTC_MOD_NONE;
      ph_i <= dtc_pkg::PHASE_RST;
      ph_q <= dtc_pkg::PHASE_RST;
      off_i <= dtc_pkg::OFFSET_RST;
      off_q <= dtc_pkg::OFFSET_RST;
    end else if (lnk.cfg_wr) begin
      unique case (lnk.cfg_addr)
        dtc_pkg::REG_SINC: sinc_bypass <= lnk.cfg_data[dtc_pkg::SINC_BYP_BIT]; // RL19
        dtc_pkg::REG_PH_I_LO: ph_i[7:0] <= lnk.cfg_data;
        dtc_pkg::REG_PH_I_HI: ph_i[9:8] <= lnk.cfg_data[1:0];
        dtc_pkg::REG_PH_Q_LO: ph_q[7:0] <= lnk.cfg_data;
        dtc_pkg::REG_PH_Q_HI: ph_q[9:8] <= lnk.cfg_data[1:0];
        dtc_pkg::REG_OFF_I_HI: off_i[15:8] <= lnk.cfg_data; // RL14
        dtc_pkg::REG_OFF_I_LO: off_i[7:0] <= lnk.cfg_data;
        dtc_pkg::REG_OFF_Q_HI: off_q[15:8] <= lnk.cfg_data;
        dtc_pkg::REG_OFF_Q_LO: off_q[7:0] <= lnk.cfg_data;
        dtc_pkg::REG_DPCFG: begin
          bus_mode <= dtc_pkg::dtc_bus_t'(lnk.cfg_data[dtc_pkg::BUSW_LSB +: 2]);
          hb_en <= lnk.cfg_data[dtc_pkg::HB_LSB +: 3];
          premod <= lnk.cfg_data[dtc_pkg::PREMOD_BIT];
        end
        dtc_pkg::REG_MOD: mod_sel <= dtc_pkg::dtc_mod_t'(lnk.cfg_data[2:0]);
        default: ;
      endcase
    end
  end

  // bus unpacking: byte mode I hi, I lo, Q hi, Q lo; word mode I then Q; dual {Q,I}
  logic [1:0] beat;
  logic signed [15:0] asm_i;
  logic signed [15:0] asm_q;
  logic pend;
  logic thr;
  wire take = lnk.bus_valid && lnk.bus_ready;
  wire [1:0] last_beat = (bus_mode == dtc_pkg::DTC_BUS_BYTE) ? dtc_pkg::LAST_BEAT_BYTE :
                         (bus_mode == dtc_pkg::DTC_BUS_WORD) ? dtc_pkg::LAST_BEAT_WORD : 2'd0; // RL3
  wire [7:0] bb = lnk.bus_data[7:0];
  wire [15:0] bw = lnk.bus_data[15:0];
  wire signed [15:0] beat_i = (bus_mode == dtc_pkg::DTC_BUS_DUAL) ? lnk.bus_data[15:0] :
                              (bus_mode == dtc_pkg::DTC_BUS_WORD) ? ((beat == 2'd0) ? bw : asm_i) :
                              (beat == 2'd0) ? {bb, asm_i[7:0]} :
                              (beat == 2'd1) ? {asm_i[15:8], bb} : asm_i;
  wire signed [15:0] beat_q = (bus_mode == dtc_pkg::DTC_BUS_DUAL) ? lnk.bus_data[31:16] :
                              (bus_mode == dtc_pkg::DTC_BUS_WORD) ? ((beat == 2'd1) ? bw : asm_q) :
                              (beat == 2'd2) ? {bb, asm_q[7:0]} :
                              (beat == 2'd3) ? {asm_q[15:8], bb} : asm_q;
  wire sample_done = take && (beat == last_beat);

  // 2^stages outputs per input sample
  logic [3:0] emit_cnt;
  wire [1:0] n_stages = 2'({1'b0, hb_en[0]} + {1'b0, hb_en[1]} + {1'b0, hb_en[2]});
  wire [3:0] n_out = 4'(4'd1 << n_stages); // RL4 RL2
  wire load = pend && (emit_cnt <= 4'd1);
  wire next_pend = sample_done || (pend && !load);
  // dual-word, three stages: bus on every other cycle
  wire dual_full = (bus_mode == dtc_pkg::DTC_BUS_DUAL) && (hb_en == 3'b111); // RL3 RL1
  wire next_thr = dual_full ? !thr : 1'b1;
  wire emit = (emit_cnt != 4'd0);

  // beat assembly and back-pressure toward the host
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      beat <= 2'd0;
      asm_i <= '0;
      asm_q <= '0;
      pend <= 1'b0;
      thr <= 1'b0;
      lnk.bus_ready <= 1'b0;
    end else begin
      pend <= next_pend;
      thr <= next_thr;
      lnk.bus_ready <= !next_pend && next_thr; // RL1
      if (take) begin
        asm_i <= beat_i;
        asm_q <= beat_q;
        beat <= (beat == last_beat) ? 2'd0 : beat + 2'd1; // RL3
      end
    end
  end

  // hold stage; premodulation negates every other input sample
  logic signed [15:0] held_i;
  logic signed [15:0] held_q;
  logic pm_phase;
  wire pm_neg = premod && pm_phase; // RL22
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_i <= '0;
      held_q <= '0;
      pm_phase <= 1'b0;
      emit_cnt <= 4'd0;
    end else if (load) begin
      held_i <= pm_neg ? dtc_pkg::dtc_sat16(-40'(asm_i)) : asm_i; // RL22
      held_q <= pm_neg ? dtc_pkg::dtc_sat16(-40'(asm_q)) : asm_q;
      pm_phase <= !pm_phase;
      emit_cnt <= n_out; // RL4
    end else if (emit) begin
      emit_cnt <= emit_cnt - 4'd1;
    end
  end

  // coarse modulation at the output rate
  logic signed [15:0] mix_i;
  logic signed [15:0] mix_q;
  logic mix_v;
  dtc_mixer dtc_mixer_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .mode(mod_sel),
    .step_en(emit),
    .in_i(held_i),
    .in_q(held_q),
    .out_i(mix_i),
    .out_q(mix_q),
    .out_valid(mix_v)
  );

  // linear skew: subtract a code-scaled share of the other channel
  function automatic logic signed [15:0] skew(input logic signed [15:0] a, input logic signed [15:0] b,
                                              input logic signed [9:0] code);
    logic signed [39:0] p;
    p = 40'(code) * 40'(b);
    return dtc_pkg::dtc_sat16(40'(a) - (p >>> dtc_pkg::PHASE_SHIFT));
  endfunction : skew

  // phase correction then offset add; offsets wrap, software keeps them in range
  logic signed [15:0] ph_out_i;
  logic signed [15:0] ph_out_q;
  logic ph_v;
  logic signed [15:0] tap_i [dtc_pkg::SINC_TAPS];
  logic signed [15:0] tap_q [dtc_pkg::SINC_TAPS];
  logic tap_v;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_out_i <= '0;
      ph_out_q <= '0;
      ph_v <= 1'b0;
    end else begin
      ph_v <= mix_v;
      ph_out_i <= skew(mix_i, mix_q, ph_i); // RL10 RL11 RL13
      ph_out_q <= skew(mix_q, mix_i, ph_q); // RL12
    end
  end

  // tap line, offset applied on entry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tap_v <= 1'b0;
      for (int k = 0; k < dtc_pkg::SINC_TAPS; k++) begin
        tap_i[k] <= '0;
        tap_q[k] <= '0;
      end
    end else begin
      tap_v <= ph_v;
      if (ph_v) begin
        tap_i[0] <= ph_out_i + off_i; // RL14 RL16
        tap_q[0] <= ph_out_q + off_q;
        for (int k = 1; k < dtc_pkg::SINC_TAPS; k++) begin
          tap_i[k] <= tap_i[k-1];
          tap_q[k] <= tap_q[k-1];
        end
      end
    end
  end

  // nine-tap inverse sinc; peaking is paid for by about 3.2 dB loss at dc
  function automatic logic signed [15:0] sinc(input logic signed [15:0] t [dtc_pkg::SINC_TAPS]);
    logic signed [39:0] acc;
    acc = '0;
    for (int k = 0; k < dtc_pkg::SINC_TAPS; k++) begin
      acc = acc + 40'(t[k]) * 40'(dtc_pkg::SINC_COEF[k]);
    end
    return dtc_pkg::dtc_sat16(acc >>> dtc_pkg::SINC_SHIFT);
  endfunction : sinc

  // converter outputs; bypass takes the newest tap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dac_i <= '0;
      dac_q <= '0;
      dac_stb <= 1'b0;
    end else begin
      dac_stb <= tap_v;
      if (tap_v) begin
        dac_i <= sinc_bypass ? tap_i[0] : sinc(tap_i); // RL17 RL18 RL19
        dac_q <= sinc_bypass ? tap_q[0] : sinc(tap_q);
      end
    end
  end
endmodule : dtc_device
`default_nettype wire

// File: rtl/dtc_pkg.sv
// shared constants, types and helpers of the datapath
package dtc_pkg;
  // device configuration map (8-bit registers)
  localparam logic [7:0] REG_SINC = 8'h1b;
  localparam int SINC_BYP_BIT = 6;
  localparam logic [7:0] REG_PH_I_LO = 8'h38;
  localparam logic [7:0] REG_PH_I_HI = 8'h39;
  localparam logic [7:0] REG_PH_Q_LO = 8'h3a;
  localparam logic [7:0] REG_PH_Q_HI = 8'h3b;
  localparam logic [7:0] REG_OFF_I_HI = 8'h3c;
  localparam logic [7:0] REG_OFF_I_LO = 8'h3d;
  localparam logic [7:0] REG_OFF_Q_HI = 8'h3e;
  localparam logic [7:0] REG_OFF_Q_LO = 8'h3f;
  localparam logic [7:0] REG_DPCFG = 8'h40;
  localparam logic [7:0] REG_MOD = 8'h41;
  // fields of the datapath configuration register
  localparam int BUSW_LSB = 0;
  localparam int HB_LSB = 2;
  localparam int PREMOD_BIT = 5;
  // reset values
  localparam logic [9:0] PHASE_RST = 10'h000;
  localparam logic [15:0] OFFSET_RST = 16'h0000;
  localparam logic SINC_BYP_RST = 1'b0;
  // bus width modes and beats per sample
  typedef enum logic [1:0] {
    DTC_BUS_BYTE = 2'b00,
    DTC_BUS_WORD = 2'b01,
    DTC_BUS_DUAL = 2'b10
  } dtc_bus_t;
  localparam logic [1:0] LAST_BEAT_BYTE = 2'h3;
  localparam logic [1:0] LAST_BEAT_WORD = 2'h1;
  // coarse modulation settings
  typedef enum logic [2:0] {
    DTC_MOD_NONE = 3'b000,
    DTC_MOD_HALF = 3'b001,
    DTC_MOD_QUARTER = 3'b010,
    DTC_MOD_3QUARTER = 3'b011,
    DTC_MOD_EIGHTH = 3'b100
  } dtc_mod_t;
  // sqrt(2)/2 in q1.15
  localparam logic signed [16:0] R_COEF = 17'sh05a82;
  localparam int R_SHIFT = 15;
  // phase skew gain per code about 2^-14
  localparam int PHASE_SHIFT = 14;
  // inverse-sinc taps, q2.9, dc gain about 0.69
  localparam int SINC_TAPS = 9;
  localparam int SINC_SHIFT = 9;
  localparam logic signed [11:0] SINC_COEF [SINC_TAPS] = '{
    12'sh002, 12'shffc, 12'sh00a, 12'shfdd, 12'sh198, 12'shfdd, 12'sh00a, 12'shffc, 12'sh002};
  // host controller word offsets
  localparam logic [7:0] H_CTRL = 8'h00;
  localparam logic [7:0] H_CFG = 8'h04;
  localparam logic [7:0] H_SAMPLE = 8'h08;
  localparam logic [7:0] H_STATUS = 8'h0c;
  localparam int CFG_ADDR_LSB = 8;

  // clamp a wide signed value into a 16-bit twos-complement sample
  function automatic logic signed [15:0] dtc_sat16(input logic signed [39:0] v);
    if (v > 40'sh00_0000_7fff) begin
      return 16'sh7fff;
    end
    if (v < -40'sh00_0000_8000) begin
      return -16'sh8000;
    end
    return v[15:0];
  endfunction : dtc_sat16
endpackage : dtc_pkg

// File: rtl/dtc_if.sv
// host to datapath link: config port and sample bus
`timescale 1ns/1ps
`default_nettype none
interface dtc_if;
  logic cfg_wr;
  logic [7:0] cfg_addr;
  logic [7:0] cfg_data;
  logic [31:0] bus_data;
  logic bus_valid;
  logic bus_ready;
  modport dev (
    input cfg_wr,
    input cfg_addr,
    input cfg_data,
    input bus_data,
    input bus_valid,
    output bus_ready
  );
  modport host (
    output cfg_wr,
    output cfg_addr,
    output cfg_data,
    output bus_data,
    output bus_valid,
    input bus_ready
  );
endinterface : dtc_if
`default_nettype wire

// File: rtl/dtc_mixer.sv
// coarse quadrature modulation mixer, one step per output sample
`timescale 1ns/1ps
`default_nettype none
module dtc_mixer (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire dtc_pkg::dtc_mod_t mode,
  input wire logic step_en,
  // sample in
  input wire logic signed [15:0] in_i,
  input wire logic signed [15:0] in_q,
  // sample out
  output logic signed [15:0] out_i,
  output logic signed [15:0] out_q,
  output logic out_valid
);
  dtc_pkg::dtc_mod_t mode_q;
  logic [2:0] step;

  // saturating negate, -32768 has no positive twin
  function automatic logic signed [15:0] neg(input logic signed [15:0] x);
    return dtc_pkg::dtc_sat16(-40'(x));
  endfunction : neg

  // r times a 17-bit sum
  function automatic logic signed [15:0] rmul(input logic signed [16:0] s);
    logic signed [39:0] p;
    p = 40'(s) * 40'(dtc_pkg::R_COEF);
    return dtc_pkg::dtc_sat16(p >>> dtc_pkg::R_SHIFT);
  endfunction : rmul

  // output pair for a given mode and step
  function automatic logic [31:0] pick(input dtc_pkg::dtc_mod_t m, input logic [2:0] k,
                                       input logic signed [15:0] i, input logic signed [15:0] q,
                                       input logic signed [15:0] rs, input logic signed [15:0] rd);
    unique case (m)
      dtc_pkg::DTC_MOD_HALF: return k[0] ? {neg(i), neg(q)} : {i, q}; // RL7
      dtc_pkg::DTC_MOD_QUARTER: begin
        unique case (k[1:0]) // RL7
          2'd0: return {i, q};
          2'd1: return {q, neg(i)};
          2'd2: return {neg(i), neg(q)};
          default: return {neg(q), i};
        endcase
      end
      dtc_pkg::DTC_MOD_3QUARTER: begin
        unique case (k[1:0]) // RL7
          2'd0: return {i, q};
          2'd1: return {neg(q), i};
          2'd2: return {neg(i), neg(q)};
          default: return {q, neg(i)};
        endcase
      end
      dtc_pkg::DTC_MOD_EIGHTH: begin
        unique case (k) // RL8
          3'd0: return {i, q};
          3'd1: return {rs, rd};
          3'd2: return {q, neg(i)};
          3'd3: return {rd, neg(rs)};
          3'd4: return {neg(i), neg(q)};
          3'd5: return {neg(rs), neg(rd)};
          3'd6: return {neg(q), i};
          default: return {neg(rd), rs};
        endcase
      end
      default: return {i, q};
    endcase
  endfunction : pick

  // a new setting restarts the sequence at its first step
  wire mode_changed = (mode != mode_q); // RL21
  wire [2:0] cur_step = mode_changed ? 3'd0 : step;
  wire signed [15:0] rs = rmul(17'(in_i) + 17'(in_q));
  wire signed [15:0] rd = rmul(17'(in_q) - 17'(in_i));
  wire [31:0] mixed = pick(mode, cur_step, in_i, in_q, rs, rd); // RL6 RL9

  // step counter advances once per emitted sample
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= dtc_pkg::DTC_MOD_NONE;
      step <= 3'd0;
    end else begin
      mode_q <= mode;
      step <= cur_step + {2'b00, step_en}; // RL21
    end
  end

  // registered mixer result
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_i <= '0;
      out_q <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= step_en;
      if (step_en) begin
        out_i <= mixed[31:16];
        out_q <= mixed[15:0];
      end
    end
  end
endmodule : dtc_mixer
`default_nettype wire

// File: rtl/dtc_host.sv
// host end: ahb-lite registers and sample bus packing
`timescale 1ns/1ps
`default_nettype none
module dtc_host (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // link to datapath
  dtc_if.host lnk
);
  logic wr_pend;
  logic [7:0] wr_addr;
  dtc_pkg::dtc_bus_t bus_mode;
  logic tx_busy;
  logic drop;
  logic [15:0] tx_i;
  logic [15:0] tx_q;
  logic [1:0] beat;

  // address phase decode
  wire addr_ok = hsel && htrans[1] && hready;
  wire do_wr = wr_pend;
  wire wr_cfg = do_wr && (wr_addr == dtc_pkg::H_CFG);
  wire wr_smp = do_wr && (wr_addr == dtc_pkg::H_SAMPLE);
  wire wr_ctl = do_wr && (wr_addr == dtc_pkg::H_CTRL);
  wire wr_sts = do_wr && (wr_addr == dtc_pkg::H_STATUS);
  wire [7:0] rd_sel = haddr[7:0];
  wire [31:0] rd_val = (rd_sel == dtc_pkg::H_CTRL) ? {30'd0, bus_mode} :
                       (rd_sel == dtc_pkg::H_SAMPLE) ? {tx_q, tx_i} :
                       (rd_sel == dtc_pkg::H_STATUS) ? {30'd0, drop, tx_busy} : 32'd0;
  wire take = lnk.bus_valid && lnk.bus_ready;
  wire [1:0] last_beat = (bus_mode == dtc_pkg::DTC_BUS_BYTE) ? dtc_pkg::LAST_BEAT_BYTE :
                         (bus_mode == dtc_pkg::DTC_BUS_WORD) ? dtc_pkg::LAST_BEAT_WORD : 2'd0;
  wire done = take && (beat == last_beat);

  // beat content, words sent unchanged
  function automatic logic [31:0] beat_word(input dtc_pkg::dtc_bus_t m, input logic [1:0] b,
                                            input logic [15:0] i, input logic [15:0] q);
    unique case (m)
      dtc_pkg::DTC_BUS_DUAL: return {q, i}; // RL16
      dtc_pkg::DTC_BUS_WORD: return {16'd0, b[0] ? q : i};
      default: begin
        unique case (b)
          2'd0: return {24'd0, i[15:8]};
          2'd1: return {24'd0, i[7:0]};
          2'd2: return {24'd0, q[15:8]};
          default: return {24'd0, q[7:0]};
        endcase
      end
    endcase
  endfunction : beat_word

  // bus slave: no wait states, read data fetched at address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'd0;
      wr_pend <= 1'b0;
      wr_addr <= 8'd0;
    end else begin
      wr_pend <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr <= haddr[7:0];
        hrdata <= rd_val;
      end
    end
  end

  // config writes forwarded as one-cycle strobes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lnk.cfg_wr <= 1'b0;
      lnk.cfg_addr <= 8'd0;
      lnk.cfg_data <= 8'd0;
      bus_mode <= dtc_pkg::DTC_BUS_BYTE;
    end else begin
      lnk.cfg_wr <= wr_cfg;
      if (wr_cfg) begin
        lnk.cfg_addr <= hwdata[dtc_pkg::CFG_ADDR_LSB +: 8];
        lnk.cfg_data <= hwdata[7:0];
      end
      if (wr_ctl) begin
        bus_mode <= dtc_pkg::dtc_bus_t'(hwdata[1:0]);
      end
    end
  end

  // sample sender: a write while busy is dropped and flagged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_busy <= 1'b0;
      drop <= 1'b0;
      tx_i <= 16'd0;
      tx_q <= 16'd0;
      beat <= 2'd0;
      lnk.bus_valid <= 1'b0;
      lnk.bus_data <= 32'd0;
    end else begin
      // a new drop wins over a clear in the same cycle
      drop <= (wr_smp && tx_busy) || (drop && !(wr_sts && hwdata[1]));
      if (wr_smp && !tx_busy) begin
        tx_i <= hwdata[15:0];
        tx_q <= hwdata[31:16];
        tx_busy <= 1'b1;
        beat <= 2'd0;
        lnk.bus_valid <= 1'b1;
        lnk.bus_data <= beat_word(bus_mode, 2'd0, hwdata[15:0], hwdata[31:16]);
      end else if (done) begin
        tx_busy <= 1'b0;
        beat <= 2'd0;
        lnk.bus_valid <= 1'b0;
      end else if (take) begin
        beat <= beat + 2'd1; // RL1
        lnk.bus_data <= beat_word(bus_mode, beat + 2'd1, tx_i, tx_q);
      end
    end
  end
endmodule : dtc_host
`default_nettype wire

// File: bench/dtc_sva.sv
// link checker
`timescale 1ns/1ps
`default_nettype none
module dtc_sva (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_data,
  input wire logic [31:0] bus_data,
  input wire logic bus_valid,
  input wire logic bus_ready,
  // converter side
  input wire logic signed [15:0] dac_i,
  input wire logic signed [15:0] dac_q,
  input wire logic dac_stb
);
  logic [7:0] dpcfg;
  wire logic take = bus_valid && bus_ready;
  wire logic dual = dpcfg[1:0] == 2'b10;
  wire logic [2:0] stg = dpcfg[4:2];
  // shadow of the device's width and stages
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dpcfg <= 8'h00;
    end else if (cfg_wr && cfg_addr == dtc_pkg::REG_DPCFG) begin
      dpcfg <= cfg_data;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  AST_VALID_HOLD: assert property (bus_valid && !bus_ready |=> bus_valid && $stable(bus_data))
    else $error("beat changed before taken");
  AST_DUAL_GAP: assert property (dual && take |=> !bus_ready)
    else $error("ready stayed high after dual beat");
  AST_FULL_SPACING: assert property (dual && stg == 3'h7 && bus_ready |=> !bus_ready)
    else $error("ready too often with three stages");
  AST_TAKE_LATENCY: assert property (dual && stg == 3'h0 && take |-> ##6 dac_stb)
    else $error("strobe late after take");
  AST_TWO_PULSES: assert property (dual && stg == 3'h1 && take |-> ##6 dac_stb [*2])
    else $error("one stage gave no strobe pair");
  AST_EIGHT_PULSES: assert property (dual && stg == 3'h7 && take |-> ##6 dac_stb [*8])
    else $error("three stages gave no eight strobes");
  AST_STB_SPACING: assert property (dual && stg == 3'h0 && dac_stb |=> !dac_stb)
    else $error("strobes too close");
  AST_DAC_HOLD: assert property (!dac_stb |-> $stable(dac_i) && $stable(dac_q))
    else $error("output moved without strobe");
  COV_FULL: cover property (dual && stg == 3'h7 && take);
  COV_BYTE: cover property (dpcfg[1:0] == 2'b00 && take);
  COV_MOD: cover property (cfg_wr && cfg_addr == dtc_pkg::REG_MOD);
endmodule : dtc_sva
`default_nettype wire

// File: bench/test_dual_dac_tx_datapath_correction.sv
// bench: host and datapath back to back over ahb-lite
`timescale 1ns/1ps
`default_nettype none
module test_dual_dac_tx_datapath_correction;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rnd = 32'hcfb5;
  wire logic hreadyout;
  wire logic hresp;
  wire logic dac_stb;
  wire logic [31:0] hrdata;
  wire logic signed [15:0] dac_i;
  wire logic signed [15:0] dac_q;
  logic [32:0] q_exp[$];
  logic [2:0] stg[3] = '{3'h1, 3'h3, 3'h7};
  logic [15:0] tbl[8] = '{16'h3800, 16'h3902, 16'h3aff, 16'h3b01, 16'h3c12, 16'h3d34, 16'h3e80, 16'h3f01};
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  dtc_if dtc_if_inst ();
  dtc_host dtc_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .lnk(dtc_if_inst.host));
  dtc_device dtc_device_inst (.hclk(hclk), .hresetn(hresetn), .lnk(dtc_if_inst.dev), .dac_i(dac_i),
    .dac_q(dac_q), .dac_stb(dac_stb));
  dtc_sva dtc_sva_inst (.hclk(hclk), .hresetn(hresetn), .cfg_wr(dtc_if_inst.cfg_wr),
    .cfg_addr(dtc_if_inst.cfg_addr), .cfg_data(dtc_if_inst.cfg_data), .bus_data(dtc_if_inst.bus_data),
    .bus_valid(dtc_if_inst.bus_valid), .bus_ready(dtc_if_inst.bus_ready), .dac_i(dac_i), .dac_q(dac_q),
    .dac_stb(dac_stb));
  always #50 hclk = ~hclk;
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic end_sim();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  // one single transfer, paced by hready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    cmp("register", e, r);
    cmp("hresp", 32'h0, {31'h0, hresp});
  endtask : rd
  task automatic cfg(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    ahb(1'b1, dtc_pkg::H_CFG, {16'h0, a, d}, r);
  endtask : cfg
  // waits until idle, then notes n results
  task automatic send(input logic [15:0] i, input logic [15:0] q, input int n, input logic [31:0] e,
    input logic c);
    logic [31:0] r;
    do ahb(1'b0, dtc_pkg::H_STATUS, 32'h0, r); while (r[0] !== 1'b0);
    repeat (n) q_exp.push_back({c, e});
    ahb(1'b1, dtc_pkg::H_SAMPLE, {q, i}, r);
  endtask : send
  task automatic drain();
    while (q_exp.size() != 0) @(posedge hclk);
    repeat (2) @(posedge hclk);
  endtask : drain
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // expected mixer output at step n
  function automatic logic [31:0] mixf(input int m, input int n, input int i, input int q);
    int s;
    int d;
    int a[8];
    int b[8];
    s = ((i + q) * dtc_pkg::R_COEF) >>> dtc_pkg::R_SHIFT;
    d = ((q - i) * dtc_pkg::R_COEF) >>> dtc_pkg::R_SHIFT;
    a = '{default: i};
    b = '{default: q};
    if (m == 1) begin
      a = '{i, -i, i, -i, i, -i, i, -i};
      b = '{q, -q, q, -q, q, -q, q, -q};
    end
    if (m == 2) begin
      a = '{i, q, -i, -q, i, q, -i, -q};
      b = '{q, -i, -q, i, q, -i, -q, i};
    end
    if (m == 3) begin
      a = '{i, -q, -i, q, i, -q, -i, q};
      b = '{q, i, -q, -i, q, i, -q, -i};
    end
    if (m == 4) begin
      a = '{i, s, q, d, -i, -s, -q, -d};
      b = '{q, d, -i, -s, -q, -d, i, s};
    end
    return {b[n][15:0], a[n][15:0]};
  endfunction : mixf
  // each strobe takes the oldest note; unflagged ones settle
  always @(posedge hclk) begin
    if (hresetn && dac_stb === 1'b1) begin
      if (q_exp.size() == 0) begin
        cmp("spare strobe", 32'h0, 32'h1);
      end else begin
        if (q_exp[0][32]) cmp("dac", q_exp[0][31:0], {dac_q, dac_i});
        void'(q_exp.pop_front());
      end
    end
  end
  // hang guard, far above the run's length
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    logic [31:0] r;
    logic signed [15:0] a;
    logic signed [15:0] b;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // filter active without any write: steady 512 settles to 354
    for (int k = 0; k < 12; k++) send(16'h0200, 16'hfe00, 1, 32'hfe9e_0162, k > 7);
    drain();
    // second sample while busy is dropped and flagged
    q_exp.push_back({1'b1, 32'hfe9e_0162});
    ahb(1'b1, dtc_pkg::H_SAMPLE, 32'hfe00_0200, r);
    ahb(1'b1, dtc_pkg::H_SAMPLE, 32'hfe00_0200, r);
    drain();
    rd(dtc_pkg::H_STATUS, 32'h2);
    ahb(1'b1, dtc_pkg::H_STATUS, 32'h2, r);
    rd(dtc_pkg::H_STATUS, 32'h0);
    rd(dtc_pkg::H_SAMPLE, 32'hfe00_0200);
    rd(8'h10, 32'h0);
    cfg(dtc_pkg::REG_SINC, 8'h40);
    for (int w = 0; w < 3; w++) begin
      ahb(1'b1, dtc_pkg::H_CTRL, w, r);
      cfg(dtc_pkg::REG_DPCFG, w[7:0]);
      repeat (2) begin
        rnd = lfsr(rnd);
        send(rnd[15:0], rnd[31:16], 1, rnd, 1'b1);
      end
      drain();
    end
    foreach (stg[k]) begin
      cfg(dtc_pkg::REG_DPCFG, {3'h0, stg[k], 2'h2});
      send(16'h1357, 16'hc246, 1 << $countones(stg[k]), 32'hc246_1357, 1'b1);
      drain();
    end
    cfg(dtc_pkg::REG_DPCFG, 8'h22);
    send(16'h0100, 16'h0200, 1, 32'h0200_0100, 1'b1);
    send(16'h0100, 16'h0200, 1, 32'hfe00_ff00, 1'b1);
    cfg(dtc_pkg::REG_DPCFG, 8'h02);
    // seven steps per mode exposes a missed restart
    for (int m = 0; m < 5; m++) begin
      cfg(dtc_pkg::REG_MOD, m[7:0]);
      a = (m == 4) ? 16'sh2000 : 16'sh03e8;
      b = (m == 4) ? 16'sh2000 : 16'sh0bb8;
      for (int n = 0; n < 7; n++) send(a, b, 1, mixf(m, n, a, b), 1'b1);
      drain();
    end
    cfg(dtc_pkg::REG_MOD, 8'h00);
    foreach (tbl[k]) cfg(tbl[k][15:8], tbl[k][7:0]);
    send(16'h4000, 16'h4000, 1, 32'hbe02_5434, 1'b1);
    send(16'h0000, 16'h0000, 1, 32'h8001_1234, 1'b1);
    drain();
    end_sim();
  end
endmodule : test_dual_dac_tx_datapath_correction
`default_nettype wire
